// [src/upconv_pkg.sv]
package upconv_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int REG_W      = 16;
  localparam int ADDR_W     = 6;
  localparam int NUM_REGS   = 6;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ  = 1'b1;

  // Rising-edge count at which each phase ends
  localparam logic [4:0] CNT_ADDR_DONE = 5'h07;
  localparam logic [4:0] CNT_PARITY    = 5'h17;
  localparam logic [4:0] CNT_FULL      = 5'h18;

  typedef struct packed {
    logic              rw;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  data;
    logic              parity;
  } frame_type;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_MODE  = 6'h03;
  localparam logic [ADDR_W-1:0] ADDR_GATE  = 6'h05;
  localparam logic [ADDR_W-1:0] ADDR_QPH   = 6'h06;
  localparam logic [ADDR_W-1:0] ADDR_IOFF  = 6'h07;
  localparam logic [ADDR_W-1:0] ADDR_QOFF  = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_LOFLT = 6'h09;

  localparam logic [ADDR_W-1:0] REG_ADDR [NUM_REGS] =
    '{ADDR_MODE, ADDR_GATE, ADDR_QPH, ADDR_IOFF, ADDR_QOFF, ADDR_LOFLT};

  // IF mode selected, detector off, everything else cleared
  localparam logic [REG_W-1:0] RESET_MODE  = 16'h0080;
  localparam logic [REG_W-1:0] RESET_OTHER = 16'h0000;
  localparam logic [REG_W-1:0] REG_RESET [NUM_REGS] =
    '{RESET_MODE, RESET_OTHER, RESET_OTHER, RESET_OTHER, RESET_OTHER, RESET_OTHER};

  localparam int IDX_MODE  = 0;
  localparam int IDX_GATE  = 1;
  localparam int IDX_QPH   = 2;
  localparam int IDX_IOFF  = 3;
  localparam int IDX_QOFF  = 4;
  localparam int IDX_LOFLT = 5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_IF_BIT  = 7;
  localparam int DET_BIT      = 5;
  localparam int CHIP_PD_BIT  = 10;
  localparam int MIX_PD_BIT   = 14;
  localparam int AMP_PD_BIT   = 15;
  localparam int MULTIPLIER_POWER_DOWN_HI   = 13;
  localparam int MULTIPLIER_POWER_DOWN_LO   = 11;
  localparam int GATE_HI      = 6;
  localparam int GATE_LO      = 0;
  localparam int PHASE_HI     = 13;
  localparam int PHASE_LO     = 7;
  localparam int OFF_NEG_HI   = 8;
  localparam int OFF_NEG_LO   = 2;
  localparam int OFF_POS_HI   = 15;
  localparam int OFF_POS_LO   = 9;
  localparam int BPF_HI       = 3;
  localparam int BPF_LO       = 0;
  localparam int SE_HI        = 9;
  localparam int SE_LO        = 6;

  localparam logic [2:0] QUAD_ENABLE = 3'h0;
  localparam logic [2:0] QUAD_OFF    = 3'h7;

  typedef struct packed {
    logic       if_mode;
    logic       detector_on;
    logic       chip_power_down;
    logic       output_amp_power_down;
    logic       mixer_power_down;
    logic [2:0] multiplier_power_down;
    logic [6:0] mixer_gate_code;
    logic [6:0] i_phase_trim;
    logic [6:0] q_phase_trim;
    logic [6:0] i_neg_offset_trim;
    logic [6:0] i_pos_offset_trim;
    logic [6:0] q_neg_offset_trim;
    logic [6:0] q_pos_offset_trim;
    logic [3:0] lo_bandpass_select;
    logic [3:0] lo_single_ended_select;
  } config_type;

  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] addr);
    logic [2:0] idx;
    idx = 3'(NUM_REGS);
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_ADDR[i] == addr) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

endpackage

// [src/level_sync.sv]
`timescale 1ns/1ps
module level_sync #(
  parameter int                 WIDTH       = 1,
  parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------
  // Two stages; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_q <= RESET_VALUE;
      dout   <= RESET_VALUE;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

// [src/odd_parity.sv]
`timescale 1ns/1ps
module odd_parity (
  input  wire logic [22:0] bits,
  output logic             parity
);

  // ----------------------------------------------------------------
  // Makes the total count of ones odd
  // ----------------------------------------------------------------
  assign parity = ~(^bits);

endmodule

// [src/upconverter_spi_control.sv]
`timescale 1ns/1ps
module upconverter_spi_control (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              sclk,
  input  wire logic              sdi,
  input  wire logic              select_n,
  input  wire logic              select_n_second,
  input  wire logic              parity_check_on,
  output logic                   sdo,
  output logic                   sdo_oe,
  output upconv_pkg::config_type cfg,
  output logic                   quadrupler_on,
  output logic                   parity_error
);
  import upconv_pkg::*;

  // ----------------------------------------------------------------
  // Link side: shift in on the serial clock
  // ----------------------------------------------------------------
  logic                    frame_off;
  logic [4:0]              count_q;
  logic [22:0]             in_q;
  frame_type               hold_q;
  logic                    commit_tgl_q;
  logic [REG_W:0]          out_q;
  logic                    oe_q;
  logic [REG_W-1:0]        shadow_q [NUM_REGS];
  logic [REG_W-1:0]        rd_word;
  logic [2:0]              rd_idx;
  logic                    rd_parity;

  // Either select low frames a transfer
  assign frame_off = select_n & select_n_second;

  always_ff @(posedge sclk or posedge frame_off) begin
    if (frame_off) begin
      count_q <= '0;
      in_q    <= '0;
    end else if (count_q != CNT_FULL) begin
      count_q <= count_q + 5'h01;
      in_q    <= {in_q[21:0], sdi};
    end
  end

  // Link reset is asynchronous: sclk may be stopped during reset
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q       <= '0;
      commit_tgl_q <= 1'b0;
    // First bit low marks a write
    end else if (!frame_off && count_q == CNT_PARITY && in_q[22] == RW_WRITE) begin
      hold_q       <= {in_q, sdi};
      commit_tgl_q <= ~commit_tgl_q;
    end
  end

  // Shadow is frozen while a frame is open, so reading it here is safe
  assign rd_idx  = reg_index(in_q[ADDR_W-1:0]);
  assign rd_word = (rd_idx < 3'(NUM_REGS)) ? shadow_q[rd_idx] : '0;

  odd_parity u_rd_parity (
    .bits   ({RW_READ, in_q[ADDR_W-1:0], rd_word}),
    .parity (rd_parity)
  );

  // Launch on falling edge so the host samples on the next rise
  always_ff @(negedge sclk or posedge frame_off) begin
    if (frame_off) begin
      out_q <= '0;
      oe_q  <= 1'b0;
    // Load data and parity after address
    end else if (count_q == CNT_ADDR_DONE && in_q[ADDR_W] == RW_READ) begin
      out_q <= {rd_word, rd_parity};
      oe_q  <= 1'b1;
    end else if (count_q == CNT_FULL) begin
      // Parity must not linger on the pin once released
      out_q <= '0;
      oe_q  <= 1'b0;
    end else if (oe_q) begin
      out_q <= {out_q[REG_W-1:0], 1'b0};
    end
  end

  assign sdo    = out_q[REG_W];
  assign sdo_oe = oe_q;

  // ----------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------
  logic [1:0]   pins_s;
  logic         frame_off_s;
  logic         check_on_s;
  logic         tgl_s;
  logic         tgl_seen_q;
  logic         commit;
  logic         wr_parity;
  logic         parity_ok;
  logic         accept;
  logic [2:0]   wr_idx;
  logic [REG_W-1:0] reg_q [NUM_REGS];

  level_sync #(
    .WIDTH       (2),
    .RESET_VALUE (2'b10)
  ) u_pin_sync (
    .clock (clock),
    .rst_b (rst_b),
    .din   ({frame_off, parity_check_on}),
    .dout  (pins_s)
  );

  assign frame_off_s = pins_s[1];
  assign check_on_s  = pins_s[0];

  level_sync #(
    .WIDTH       (1),
    .RESET_VALUE (1'b0)
  ) u_commit_sync (
    .clock (clock),
    .rst_b (rst_b),
    .din   (commit_tgl_q),
    .dout  (tgl_s)
  );

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_seen_q <= tgl_s;
    end
  end

  assign commit = tgl_s ^ tgl_seen_q;

  // Odd check on a written frame
  odd_parity u_wr_parity (
    .bits   (hold_q[23:1]),
    .parity (wr_parity)
  );

  assign parity_ok = (hold_q.parity == wr_parity);
  assign accept    = parity_ok | ~check_on_s;
  assign wr_idx    = reg_index(hold_q.addr);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      parity_error <= 1'b0;
    end else if (commit) begin
      parity_error <= ~accept;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // All fields restored by hard reset; via reset table
  generate
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          reg_q[i] <= REG_RESET[i];
        end else if (commit && accept && wr_idx == 3'(i)) begin
          reg_q[i] <= hold_q.data;
        end
      end

      always_ff @(posedge clock) begin
        if (!rst_b) begin
          shadow_q[i] <= REG_RESET[i];
        end else if (frame_off_s) begin
          shadow_q[i] <= reg_q[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------
  // Zero quadrature, one IF
  assign cfg.if_mode                = reg_q[IDX_MODE][MODE_IF_BIT];
  assign cfg.detector_on            = reg_q[IDX_MODE][DET_BIT];
  assign cfg.chip_power_down        = reg_q[IDX_MODE][CHIP_PD_BIT];
  assign cfg.output_amp_power_down  = reg_q[IDX_MODE][AMP_PD_BIT];
  assign cfg.mixer_power_down       = reg_q[IDX_MODE][MIX_PD_BIT];
  assign cfg.multiplier_power_down  = reg_q[IDX_MODE][MULTIPLIER_POWER_DOWN_HI:MULTIPLIER_POWER_DOWN_LO];
  assign quadrupler_on              = (cfg.multiplier_power_down == QUAD_ENABLE);
  assign cfg.mixer_gate_code        = reg_q[IDX_GATE][GATE_HI:GATE_LO];
  assign cfg.i_phase_trim           = reg_q[IDX_GATE][PHASE_HI:PHASE_LO];
  assign cfg.q_phase_trim           = reg_q[IDX_QPH][PHASE_HI:PHASE_LO];
  assign cfg.i_neg_offset_trim      = reg_q[IDX_IOFF][OFF_NEG_HI:OFF_NEG_LO];
  assign cfg.i_pos_offset_trim      = reg_q[IDX_IOFF][OFF_POS_HI:OFF_POS_LO];
  assign cfg.q_neg_offset_trim      = reg_q[IDX_QOFF][OFF_NEG_HI:OFF_NEG_LO];
  assign cfg.q_pos_offset_trim      = reg_q[IDX_QOFF][OFF_POS_HI:OFF_POS_LO];
  assign cfg.lo_bandpass_select     = reg_q[IDX_LOFLT][BPF_HI:BPF_LO];
  assign cfg.lo_single_ended_select = reg_q[IDX_LOFLT][SE_HI:SE_LO];

endmodule

// [test/upconverter_spi_control_sva.sv]
`timescale 1ns/1ps
module upconverter_spi_control_sva (
  input logic                   clock,
  input logic                   rst_b,
  input logic                   sclk,
  input logic                   sdi,
  input logic                   select_n,
  input logic                   select_n_second,
  input logic                   sdo,
  input logic                   sdo_oe,
  input upconv_pkg::config_type cfg,
  input logic                   quadrupler_on,
  input logic                   parity_error
);
  import upconv_pkg::*;
  // ----
  // Frame position
  // ----
  logic       idle;
  logic [4:0] cnt_q;
  logic       rw_q;
  assign idle = select_n & select_n_second;
  // Cleared by select, since sclk stops between frames
  always_ff @(posedge sclk or posedge idle) begin
    if (idle) begin
      cnt_q <= 5'h00;
      rw_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 5'(cnt_q != 5'h1f);
      rw_q  <= (cnt_q == 5'h00) ? sdi : rw_q;
    end
  end
  // ----
  // Properties
  // ----
  property p_oe_early;
    @(posedge sclk) disable iff (!rst_b) cnt_q < 5'h07 |-> !sdo_oe;
  endproperty
  a_oe_early: assert property (p_oe_early) else $error("sdo_oe high before data phase");
  property p_oe_read;
    @(posedge sclk) disable iff (!rst_b) rw_q && cnt_q >= 5'h07 && cnt_q <= 5'h17 |-> sdo_oe;
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("sdo_oe low in read data phase");
  property p_oe_write;
    @(posedge sclk) disable iff (!rst_b) !rw_q && cnt_q >= 5'h07 |-> !sdo_oe;
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("sdo_oe high in write frame");
  property p_oe_idle;
    @(posedge clock) disable iff (!rst_b) select_n && select_n_second |-> !sdo_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdo_oe high while deselected");
  property p_sdo_quiet;
    @(posedge clock) disable iff (!rst_b) !sdo_oe |-> !sdo;
  endproperty
  a_sdo_quiet: assert property (p_sdo_quiet) else $error("sdo high while not driven");
  property p_quad_dec;
    @(posedge clock) disable iff (!rst_b) quadrupler_on == (cfg.multiplier_power_down == 3'h0);
  endproperty
  a_quad_dec: assert property (p_quad_dec) else $error("quadrupler_on decode wrong");
  property p_reset_vals;
    @(posedge clock) disable iff (!rst_b)
      $rose(rst_b) |-> cfg.if_mode && !cfg.detector_on && quadrupler_on && !parity_error;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  property p_cfg_commit;
    @(posedge clock) disable iff (!rst_b) !$stable(cfg) |-> select_n && select_n_second;
  endproperty
  a_cfg_commit: assert property (p_cfg_commit) else $error("cfg changed inside a frame");
  c_read: cover property (@(posedge sclk) rw_q && cnt_q == 5'h17);
  c_cfg: cover property (@(posedge clock) !$stable(cfg));
  c_perr: cover property (@(posedge clock) $rose(parity_error));
endmodule
bind upconverter_spi_control upconverter_spi_control_sva upconverter_spi_control_sva_inst (.clock, .rst_b,
  .sclk, .sdi, .select_n, .select_n_second, .sdo, .sdo_oe, .cfg, .quadrupler_on, .parity_error);

// [test/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk,
  output logic sdi,
  output logic select_n,
  input  logic sdo
);
  import upconv_pkg::*;
  // ----
  // Host side of the link
  // ----
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    select_n = 1'b1;
  end
  task automatic xfer(input frame_type f, input int n, output logic [15:0] rd, output logic rp);
    logic [23:0] b;
    b = f;
    rd = 16'h0000;
    rp = 1'b0;
    #5 select_n = 1'b0;
    #6;
    for (int k = 0; k < n; k++) begin
      sdi = b[23-k];
      #6 sclk = 1'b1;
      rd[(22-k)&15] = (k >= 7 && k < 23) ? sdo : rd[(22-k)&15];
      rp = (k == 23) ? sdo : rp;
      #6 sclk = 1'b0;
    end
    #6 select_n = 1'b1;
    // Released line shows the inverse, not a stale value
    sdi = ~sdi;
  endtask
endmodule

// [test/tb_upconverter_spi_control.sv]
`timescale 1ns/1ps
module tb_upconverter_spi_control;
  import upconv_pkg::*;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        pchk  = 1'b0;
  logic        sclk, sdi, sel, sdo, oe, qon, perr, rp;
  config_type  cfg;
  logic [15:0] m [NUM_REGS];
  logic [15:0] rd;
  logic [31:0] seed = 32'h4293_3f9e;
  int          failures = 0;
  int          tests_run = 0;
  // ----
  // Setup
  // ----
  always #4 clock = ~clock;
  upconverter_spi_control upconverter_spi_control_inst (.clock, .rst_b, .sclk, .sdi, .select_n(sel),
    .select_n_second(sel), .parity_check_on(pchk), .sdo, .sdo_oe(oe), .cfg, .quadrupler_on(qon), .parity_error(perr));
  spi_host_model spi_host_model_inst (.sclk, .sdi, .select_n(sel), .sdo);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic odd(input logic [22:0] b);
    return ~^b;
  endfunction
  function automatic config_type exp_cfg();
    config_type c;
    c = {m[0][7], m[0][5], m[0][10], m[0][15], m[0][14], m[0][13:11], m[1][6:0], m[1][13:7], m[2][13:7],
      m[3][8:2], m[3][15:9], m[4][8:2], m[4][15:9], m[5][3:0], m[5][9:6]};
    return c;
  endfunction
  task automatic chk(input string n, input logic [79:0] e, input logic [79:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Parity mode: 0 true, 1 flipped, 2 zero
  task automatic xfer(input logic rw, input logic [5:0] a, input logic [15:0] d, input logic [1:0] pm, input int n);
    frame_type f;
    f = {rw, a, d, (pm == 2'h2) ? 1'b0 : odd({rw, a, d}) ^ pm[0]};
    spi_host_model_inst.xfer(f, n, rd, rp);
    repeat (10) @(posedge clock);
  endtask
  task automatic check_all();
    for (int i = 0; i < NUM_REGS; i++) begin
      xfer(1'b1, REG_ADDR[i], 16'h0000, 2'h2, 24);
      chk("read data", 80'(m[i]), 80'(rd));
      chk("read parity", 80'(odd({1'b1, REG_ADDR[i], m[i]})), 80'(rp));
      chk("sdo released", 80'(2'b00), 80'({oe, sdo}));
    end
    chk("cfg", 80'(exp_cfg()), 80'(cfg));
    chk("quad on", 80'(m[0][13:11] == 3'h0), 80'(qon));
  endtask
  // ----
  // Tests
  // ----
  initial begin
    m = REG_RESET;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    chk("reset parity error", 80'(1'b0), 80'(perr));
    xfer(1'b0, 6'h0a, 16'he700, 2'h0, 24);
    xfer(1'b1, 6'h0a, 16'h0000, 2'h2, 24);
    chk("unmapped read", 80'({16'h0000, odd({1'b1, 6'h0a, 16'h0000})}), 80'({rd, rp}));
    check_all();
    $display("Test reset done");
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        m[i] = (r == 0) ? 16'hffff : (r == 1) ? 16'h0000 : 16'(xs());
        xfer(1'b0, REG_ADDR[i], m[i], 2'h0, 24);
      end
      check_all();
    end
    $display("Test write and read done");
    pchk <= 1'b1;
    xfer(1'b0, ADDR_GATE, 16'h1234, 2'h1, 24);
    chk("parity error set", 80'(1'b1), 80'(perr));
    xfer(1'b0, ADDR_QPH, 16'h5555, 2'h0, 20);
    check_all();
    pchk <= 1'b0;
    xfer(1'b0, ADDR_GATE, 16'h1235, 2'h2, 24);
    m[IDX_GATE] = 16'h1235;
    chk("parity error clear", 80'(1'b0), 80'(perr));
    check_all();
    $display("Test parity and short frame done");
    // Second reset with the flag set and fields dirty
    pchk <= 1'b1;
    xfer(1'b0, ADDR_MODE, 16'h2c20, 2'h1, 24);
    chk("parity error before reset", 80'(1'b1), 80'(perr));
    rst_b <= 1'b0;
    m = REG_RESET;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    chk("parity error after reset", 80'(1'b0), 80'(perr));
    check_all();
    $display("Test mid-run reset done");
    stop_test();
  end
  initial begin
    #200_000;
    failures++;
    stop_test();
  end
endmodule
